// File: sfcf_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.svh"

module sfcf_flags
    import sfcf_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // monitor fault levels, asynchronous
    input wire sfcf_supply_evt_t supply_fault,
    input wire sfcf_clock_evt_t clock_fault,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // address map

    localparam logic [ADDR_W-1:0] SUPPLY_ADDR =
        ADDR_W'(`SFCF_SUPPLY_IDX) << `SFCF_WORD_SHIFT;
    localparam logic [ADDR_W-1:0] CLOCK_ADDR =
        ADDR_W'(`SFCF_CLOCK_IDX) << `SFCF_WORD_SHIFT;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR =
        ADDR_W'(`SFCF_IRQ_STAT_IDX) << `SFCF_WORD_SHIFT;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR =
        ADDR_W'(`SFCF_IRQ_MASK_IDX) << `SFCF_WORD_SHIFT;
    localparam logic [ADDR_W-1:0] LIVE_ADDR =
        ADDR_W'(`SFCF_LIVE_IDX) << `SFCF_WORD_SHIFT;

    function automatic sfcf_sel_t decode(input logic [ADDR_W-1:0] addr);
        sfcf_sel_t sel;
        sel = sfcf_sel_none;
        if (addr == SUPPLY_ADDR) begin
            sel = sfcf_sel_supply;
        end else if (addr == CLOCK_ADDR) begin
            sel = sfcf_sel_clock;
        end else if (addr == IRQ_STAT_ADDR) begin
            sel = sfcf_sel_irq_stat;
        end else if (addr == IRQ_MASK_ADDR) begin
            sel = sfcf_sel_irq_mask;
        end else if (addr == LIVE_ADDR) begin
            sel = sfcf_sel_live;
        end
        return sel;
    endfunction

    // expand byte strobes into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // monitor synchronisers

    logic [15:0] sup_meta_r;
    logic [15:0] sup_sync_r;
    logic [2:0] clk_meta_r;
    logic [2:0] clk_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_meta_r <= 16'h0000;
            sup_sync_r <= 16'h0000;
            clk_meta_r <= 3'h0;
            clk_sync_r <= 3'h0;
        end else begin
            sup_meta_r <= supply_fault;
            sup_sync_r <= sup_meta_r;
            clk_meta_r <= clock_fault;
            clk_sync_r <= clk_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb phases

    logic apb_setup;
    logic apb_access;
    logic wr_en;
    sfcf_sel_t acc_sel;
    logic [31:0] wr_bits;
    logic [31:0] wr_lanes;

    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign wr_en = apb_access & pwrite;
    assign acc_sel = decode(paddr);
    assign wr_lanes = lane_mask(pstrb);
    assign wr_bits = pwdata & wr_lanes;
    // zero wait states: every access phase completes at once
    assign pready = apb_access;

    ////////////////////////////////////////////////////////////////////////////
    // fault flag registers

    logic [15:0] supply_r;
    logic [15:0] supply_nxt;
    logic [15:0] sup_clr;
    logic [2:0] clock_r;
    logic [2:0] clock_nxt;
    logic [2:0] clk_clr;
    logic [15:0] clock_word;

    assign sup_clr = (wr_en && acc_sel == sfcf_sel_supply) ? wr_bits[15:0] : 16'h0000;
    assign clk_clr = (wr_en && acc_sel == sfcf_sel_clock) ? wr_bits[2:0] : 3'h0;

    // written ones restore, zeros are ignored; a present fault beats the restore
    assign supply_nxt = (supply_r | sup_clr) & ~sup_sync_r;
    assign clock_nxt = (clock_r | clk_clr) & ~clk_sync_r;
    assign clock_word = `SFCF_CLOCK_RSVD | 16'(clock_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_r <= `SFCF_SUPPLY_RST;
        end else begin
            supply_r <= supply_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_r <= `SFCF_CLOCK_FLAG_RST;
        end else begin
            clock_r <= clock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [31:0] evt_vec;
    logic [31:0] ist_r;
    logic [31:0] ist_nxt;
    logic [31:0] ist_clr;
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] mask_wm;
    logic irq_r;

    assign evt_vec = 32'(sup_sync_r) | (32'(clk_sync_r) << `SFCF_IRQ_CLK_LSB);
    assign ist_clr = (wr_en && acc_sel == sfcf_sel_irq_stat) ? wr_bits : 32'h0000_0000;
    // a new event wins over a same-cycle clear
    assign ist_nxt = ((ist_r & ~ist_clr) | evt_vec) & `SFCF_IRQ_USED;
    assign mask_wm = (wr_en && acc_sel == sfcf_sel_irq_mask) ? wr_lanes : 32'h0000_0000;
    assign mask_nxt = ((mask_r & ~mask_wm) | (pwdata & mask_wm)) & `SFCF_IRQ_USED;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= `SFCF_IRQ_STAT_RST;
        end else begin
            ist_r <= ist_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `SFCF_IRQ_MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist_nxt & mask_nxt);
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // read path, captured in the setup phase

    logic [31:0] rd_mux;
    logic rd_err;
    logic [31:0] prdata_r;
    logic pslverr_r;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (acc_sel)
            sfcf_sel_supply: begin
                rd_mux = 32'(supply_r);
            end
            sfcf_sel_clock: begin
                rd_mux = 32'(clock_word);
            end
            sfcf_sel_irq_stat: begin
                rd_mux = ist_r;
            end
            sfcf_sel_irq_mask: begin
                rd_mux = mask_r;
            end
            sfcf_sel_live: begin
                rd_mux = evt_vec;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (apb_setup) begin
            pslverr_r <= rd_err;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r & apb_access;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic out_of_reset_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_of_reset_r <= 1'b0;
        end else begin
            out_of_reset_r <= 1'b1;
        end
    end

    supply_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !out_of_reset_r |-> (supply_r == `SFCF_SUPPLY_RST)
    ) else $error("supply flags not all one after reset");

    clock_word_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && !pwrite && acc_sel == sfcf_sel_clock)
            |=> (prdata[15:0] & ~16'(`SFCF_CLOCK_FLAG_RST)) == `SFCF_CLOCK_RSVD
    ) else $error("clock register reserved bits read wrong");

    clock_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !out_of_reset_r |-> (clock_word == `SFCF_CLOCK_RST)
    ) else $error("clock register not at reset value");

    supply_fault_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((supply_r & $past(sup_sync_r)) == 16'h0000)
    ) else $error("supply fault did not drive its flag low");

    clock_fault_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((clock_r & $past(clk_sync_r)) == 3'h0)
    ) else $error("clock fault did not drive its flag low");

    fault_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && acc_sel == sfcf_sel_supply)
            |=> ((~supply_r & $past(sup_clr) & ~$past(sup_sync_r)) == 16'h0000)
    ) else $error("written one did not restore supply flag");

    fault_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((supply_r & ~$past(supply_r) & ~$past(sup_clr)) == 16'h0000)
    ) else $error("supply flag rose without a written one");

    clock_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((clock_r & ~$past(clock_r) & ~$past(clk_clr)) == 3'h0)
    ) else $error("clock flag rose without a written one");

    event_sticky_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (evt_vec != 32'h0000_0000) |=> ((ist_r & $past(evt_vec)) == $past(evt_vec))
    ) else $error("event did not set interrupt status");

    irq_mask_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mask_r == 32'h0000_0000) |-> !irq
    ) else $error("interrupt raised with all sources masked");

    slverr_map_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && acc_sel == sfcf_sel_none) |=> (pslverr && pready)
    ) else $error("unmapped address not answered with error");

    clock_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && acc_sel == sfcf_sel_clock)
            |=> ((~clock_r & $past(clk_clr) & ~$past(clk_sync_r)) == 3'h0)
    ) else $error("written one did not restore clock flag");

    supply_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && !pwrite && acc_sel == sfcf_sel_supply)
            |=> (prdata == 32'($past(supply_r)))
    ) else $error("supply read data differs from flags");

    upper_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && !pwrite && (acc_sel == sfcf_sel_supply || acc_sel == sfcf_sel_clock))
            |=> (prdata[31:16] == 16'h0000)
    ) else $error("flag register upper half not zero");

    supply_cause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((~supply_r & $past(supply_r) & ~$past(sup_sync_r)) == 16'h0000)
    ) else $error("supply flag fell without a fault");

    clock_cause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |=> ((~clock_r & $past(clock_r) & ~$past(clk_sync_r)) == 3'h0)
    ) else $error("clock flag fell without a fault");

    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_of_reset_r |-> (irq == |(ist_r & mask_r))
    ) else $error("interrupt level disagrees with status and mask");

    status_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && acc_sel == sfcf_sel_irq_stat)
            |=> ((ist_r & $past(ist_clr) & ~$past(evt_vec)) == 32'h0000_0000)
    ) else $error("written one did not clear interrupt status");

    mapped_ok_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && acc_sel != sfcf_sel_none) |=> !pslverr
    ) else $error("mapped address answered with error");

    unmapped_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_setup && !pwrite && acc_sel == sfcf_sel_none) |=> (prdata == 32'h0000_0000)
    ) else $error("unmapped read returned data");

endmodule

`default_nettype wire

// File: sfcf_regs.svh
`ifndef SFCF_REGS_SVH
`define SFCF_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is index shifted by the word shift
`define SFCF_SUPPLY_IDX 8'h03
`define SFCF_CLOCK_IDX 8'h04
`define SFCF_IRQ_STAT_IDX 8'h08
`define SFCF_IRQ_MASK_IDX 8'h09
`define SFCF_LIVE_IDX 8'h0A
`define SFCF_WORD_SHIFT 2

////////////////////////////////////////////////////////////////////////////////
// reset values and fixed fields
`define SFCF_SUPPLY_RST 16'hFFFF
`define SFCF_CLOCK_RST 16'hFC07
`define SFCF_CLOCK_RSVD 16'hFC00
`define SFCF_CLOCK_FLAG_RST 3'h7
`define SFCF_IRQ_MASK_RST 32'h0000_0000
`define SFCF_IRQ_STAT_RST 32'h0000_0000
`define SFCF_IRQ_USED 32'h0007_FFFF
`define SFCF_IRQ_CLK_LSB 16

`endif

// File: sfcf_pkg.sv
`default_nettype none

package sfcf_pkg;

    // monitor fault indications, active high, ordered as the supply flag word
    typedef struct packed {
        logic analog_rail_overvoltage;
        logic analog_rail_undervoltage;
        logic io_rail_overvoltage;
        logic io_rail_undervoltage;
        logic digital_rail_overvoltage;
        logic digital_rail_undervoltage;
        logic analog_rail_oscillation;
        logic io_rail_oscillation;
        logic digital_rail_oscillation;
        logic analog_regulator_overtemp_warn;
        logic io_regulator_overtemp_warn;
        logic analog_regulator_current_limit;
        logic io_regulator_current_limit;
        logic analog_ground_a_open;
        logic analog_ground_b_open;
        logic digital_ground_open;
    } sfcf_supply_evt_t;

    // ordered as the low bits of the clock flag word
    typedef struct packed {
        logic main_clock_freq_fault;
        logic diag_oscillator_watchdog;
        logic main_clock_watchdog;
    } sfcf_clock_evt_t;

    typedef enum {
        sfcf_sel_none,
        sfcf_sel_supply,
        sfcf_sel_clock,
        sfcf_sel_irq_stat,
        sfcf_sel_irq_mask,
        sfcf_sel_live
    } sfcf_sel_t;

endpackage

`default_nettype wire

// File: sfcf_monitor_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfcf_monitor_model
    import sfcf_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fault requests from the scenario
    input wire logic [15:0] supply_req,
    input wire logic [2:0] clock_req,
    // monitor fault levels
    output var sfcf_supply_evt_t supply_fault,
    output var sfcf_clock_evt_t clock_fault
);

    // levels change just after an edge, like a real monitor output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_fault <= '0;
            clock_fault <= '0;
        end else begin
            supply_fault <= supply_req;
            clock_fault <= clock_req;
        end
    end

endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import sfcf_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] sreq;
    logic [2:0] creq;
    sfcf_supply_evt_t sfault;
    sfcf_clock_evt_t cfault;
    int miscompares, cmp_count;

    sfcf_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_fault(sfault), .clock_fault(cfault),
        .irq(irq));

    sfcf_monitor_model mon (.pclk(pclk), .presetn(presetn), .supply_req(sreq),
        .clock_req(creq), .supply_fault(sfault), .clock_fault(cfault));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    // raise monitor levels, hold them, drop and let the synchroniser settle
    task automatic fault(input logic [15:0] s, input logic [2:0] c, input int hold);
        @(posedge pclk);
        sreq <= s;
        creq <= c;
        repeat (hold) @(posedge pclk);
        sreq <= 16'h0;
        creq <= 3'h0;
        repeat (5) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #40000;
        miscompares++;
        stop_test();
    end

    initial begin
        logic [31:0] exp;
        miscompares = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        sreq = 16'h0;
        creq = 3'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("supply", 12'h00C, 32'h0000FFFF);
        rdchk("clock", 12'h010, 32'h0000FC07);
        rdchk("mask", 12'h024, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            exp = 32'h0000FFFF & ~(32'h1 << i);
            fault(16'h1 << i, 3'h0, 4);
            rdchk("supply flag", 12'h00C, exp);
            apb(1'b1, 12'h00C, 32'h0);
            rdchk("supply zero write", 12'h00C, exp);
            apb(1'b1, 12'h00C, 32'h1 << i);
            rdchk("supply cleared", 12'h00C, 32'h0000FFFF);
        end
        $display("test supply flags done");
        for (int i = 0; i < 3; i++) begin
            exp = 32'h0000FC07 & ~(32'h1 << i);
            fault(16'h0, 3'h1 << i, 4);
            rdchk("clock flag", 12'h010, exp);
            apb(1'b1, 12'h010, 32'h0000FFF8);
            rdchk("clock reserved", 12'h010, exp);
            apb(1'b1, 12'h010, 32'h1 << i);
            rdchk("clock cleared", 12'h010, 32'h0000FC07);
        end
        $display("test clock flags done");
        #1;
        check("irq masked", 32'h0, {31'h0, irq});
        rdchk("irq status", 12'h020, 32'h0007FFFF);
        apb(1'b1, 12'h020, 32'h0007FFFF);
        rdchk("irq status clear", 12'h020, 32'h0);
        apb(1'b1, 12'h024, 32'h1);
        rdchk("mask set", 12'h024, 32'h1);
        @(posedge pclk);
        sreq <= 16'h0021;
        repeat (5) @(posedge pclk);
        #1;
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h00C, 32'h0000FFFF);
        rdchk("fault wins", 12'h00C, 32'h0000FFDE);
        rdchk("live faults", 12'h028, 32'h00000021);
        @(posedge pclk);
        sreq <= 16'h0;
        repeat (5) @(posedge pclk);
        apb(1'b1, 12'h020, 32'h1);
        @(posedge pclk);
        #1;
        check("irq cleared", 32'h0, {31'h0, irq});
        rdchk("irq status left", 12'h020, 32'h20);
        apb(1'b1, 12'h00C, 32'h0000FFFF);
        rdchk("supply after clear", 12'h00C, 32'h0000FFFF);
        fault(16'h8001, 3'h0, 4);
        pstrb <= 4'h1;
        apb(1'b1, 12'h00C, 32'h0000FFFF);
        rdchk("lane write", 12'h00C, 32'h00007FFF);
        pstrb <= 4'hF;
        apb(1'b1, 12'h00C, 32'h0000FFFF);
        rdchk("lane restore", 12'h00C, 32'h0000FFFF);
        $display("test interrupt done");
        apb(1'b1, 12'h030, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, 12'h00D, 32'h0);
        check("unaligned error", 32'h1, {31'h0, err});
        check("unaligned data", 32'h0, rd);
        $display("test unmapped done");
        fault(16'h8000, 3'h4, 4);
        rdchk("supply before reset", 12'h00C, 32'h00007FFF);
        rdchk("clock before reset", 12'h010, 32'h0000FC03);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("supply after reset", 12'h00C, 32'h0000FFFF);
        rdchk("clock after reset", 12'h010, 32'h0000FC07);
        rdchk("irq status after reset", 12'h020, 32'h0);
        $display("test mid reset done");
        stop_test();
    end

endmodule

`default_nettype wire
